// ---- hdl/rhc_top.sv ----
// Host control pins of the radio transceiver: states, trigger, wake, clock.
//
// Behaviour
// [RULE1] reset pin low holds the off state and wipes all settings
// [RULE2] reset pin release enters idle with every setting at default
// [RULE3] rising trigger edge starts receive or transmit per setting
// [RULE4] trigger held high lets the start command launch the sequence
// [RULE5] wake request low moves hibernate or doze into idle
// [RULE6] host clock selectable in eight rates, default near 32.786 kHz
// [RULE7] serial link answers only while chip select is low
// [RULE8] open-drain low interrupt, assertions spaced at least 6 us
// [RULE9] host keeps serial clock at or below 8 MHz, access >= 3 us; the host model clocks the link at 12.5 MHz
// [RULE10] data sampled on leading edge, shifted out on falling edge
// [RULE11] data out floats when deselected unless configured to drive
// [RULE12] pin inputs are synchronised before any edge or level logic
`timescale 1ns/1ps
module rhc_top #(
    parameter int unsigned SEQ_CYC = rhc_pkg::SEQ_CYCLES
) (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic reset_n_i,
    input wire logic rx_tx_trigger_i,
    input wire logic wake_request_n_i,
    input wire logic serial_clock_in,
    input wire logic chip_sel_n_i,
    input wire logic mosi_i,
    output logic miso_o,
    output logic miso_oe_n_o,
    output logic irq_n_o,
    output logic irq_oe_n_o,
    output logic host_clock_out_o,
    output logic [2:0] state_o
);
    import rhc_pkg::*;

    rhc_link_if lnk ();

    rhc_serial_link u_link (
        .serial_clock_in(serial_clock_in),
        .sys_rst_i(sys_rst_i),
        .chip_sel_n_i(chip_sel_n_i),
        .mosi_i(mosi_i),
        .lnk(lnk)
    );

    // ==========================================================
    // synchronisers: {reset pin, trigger, wake, select, word toggle}
    logic [4:0] meta_q, sync_q;
    logic rst_pin_s, trig_s, wake_n_s, cs_n_s, tgl_s;

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            meta_q <= SYNC_RST;
            sync_q <= SYNC_RST;
        end else begin
            meta_q <= {reset_n_i, rx_tx_trigger_i, wake_request_n_i,
                       chip_sel_n_i, lnk.word_tgl}; // see [RULE12]
            sync_q <= meta_q;
        end
    end
    assign {rst_pin_s, trig_s, wake_n_s, cs_n_s, tgl_s} = sync_q;

    // ==========================================================
    // edge detection and command decode
    logic trig_prev_q, tgl_prev_q;
    logic trig_rise, cmd_v;
    logic [CMD_W-1:0] cmd;
    logic [ARG_W-1:0] arg;

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            trig_prev_q <= 1'b0;
            tgl_prev_q <= 1'b0;
        end else begin
            trig_prev_q <= trig_s;
            tgl_prev_q <= tgl_s;
        end
    end
    assign trig_rise = trig_s & ~trig_prev_q; // see [RULE3]
    // word is stable for eight serial clocks after its toggle
    assign cmd_v = tgl_s ^ tgl_prev_q;
    assign cmd = lnk.word[CMD_LSB +: CMD_W];
    assign arg = lnk.word[ARG_W-1:0];

    // ==========================================================
    // state machine and settings
    rhc_state_e state_q, state_d;
    logic [CLKSEL_W-1:0] clksel_q, clksel_d;
    logic seq_tx_q, seq_tx_d;
    logic miso_drv_q, miso_drv_d;
    logic [15:0] seq_cnt_q, seq_cnt_d;
    logic seq_done, irq_ack;

    always_comb begin
        state_d = state_q;
        clksel_d = clksel_q;
        seq_tx_d = seq_tx_q;
        miso_drv_d = miso_drv_q;
        seq_cnt_d = seq_cnt_q;
        seq_done = 1'b0;
        irq_ack = 1'b0;
        unique case (state_q)
            ST_OFF: begin
                state_d = ST_IDLE; // see [RULE2]
            end
            ST_IDLE: begin
                seq_cnt_d = 16'(SEQ_CYC - 1);
                if (trig_rise) begin
                    state_d = seq_tx_q ? ST_TX : ST_RX; // see [RULE3]
                end else if (cmd_v) begin
                    unique case (cmd)
                        CMD_CLKSEL: clksel_d = arg[CLKSEL_W-1:0]; // see [RULE6]
                        CMD_SEQSEL: seq_tx_d = arg[0];
                        CMD_START: begin
                            if (trig_s) begin
                                state_d = seq_tx_q ? ST_TX : ST_RX; // see [RULE4]
                            end
                        end
                        CMD_HIBERNATE: state_d = ST_HIBERNATE;
                        CMD_DOZE: state_d = ST_DOZE;
                        CMD_MISOCFG: miso_drv_d = arg[0]; // see [RULE11]
                        CMD_IRQACK: irq_ack = 1'b1;
                        default: ;
                    endcase
                end
            end
            // link commands are ignored in the low-power states; status still shifts out
            ST_HIBERNATE, ST_DOZE: begin
                if (!wake_n_s) begin
                    state_d = ST_IDLE; // see [RULE5]
                end
            end
            ST_RX, ST_TX: begin
                irq_ack = cmd_v && cmd == CMD_IRQACK;
                seq_cnt_d = seq_cnt_q - 16'h1;
                if (seq_cnt_q == 16'h0) begin
                    seq_done = 1'b1;
                    state_d = ST_IDLE;
                end
            end
        endcase
        if (!rst_pin_s) begin
            state_d = ST_OFF; // see [RULE1]
            clksel_d = CLKSEL_RST; // see [RULE1]
            seq_tx_d = SEQ_TX_RST;
            miso_drv_d = MISO_DRV_RST;
            seq_done = 1'b0;
            irq_ack = 1'b0;
        end
    end

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_q <= ST_OFF;
            clksel_q <= CLKSEL_RST;
            seq_tx_q <= SEQ_TX_RST;
            miso_drv_q <= MISO_DRV_RST;
            seq_cnt_q <= 16'h0;
        end else begin
            state_q <= state_d;
            clksel_q <= clksel_d;
            seq_tx_q <= seq_tx_d;
            miso_drv_q <= miso_drv_d;
            seq_cnt_q <= seq_cnt_d;
        end
    end

    // ==========================================================
    // interrupt: pending event, presented no faster than the gap
    logic irq_pend_q, irq_pend_d, irq_out_q, irq_out_d, irq_oe_n_q;
    logic [GAP_W-1:0] gap_q, gap_d;

    always_comb begin
        irq_pend_d = irq_pend_q;
        irq_out_d = irq_out_q;
        gap_d = (gap_q != '0) ? gap_q - GAP_W'(1) : gap_q;
        if (irq_ack) begin
            irq_out_d = 1'b0;
        end
        if (!irq_out_q && irq_pend_q && gap_q == '0) begin
            irq_out_d = 1'b1;
            irq_pend_d = 1'b0;
            gap_d = GAP_W'(IRQ_GAP_CYCLES - 1); // see [RULE8]
        end
        // a fresh event is never lost to a same-cycle acknowledge
        if (seq_done) begin
            irq_pend_d = 1'b1;
        end
        if (!rst_pin_s) begin
            irq_pend_d = 1'b0; // see [RULE1]
            irq_out_d = 1'b0;
        end
    end

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            irq_pend_q <= 1'b0;
            irq_out_q <= 1'b0;
            irq_oe_n_q <= 1'b1;
            gap_q <= '0;
        end else begin
            irq_pend_q <= irq_pend_d;
            irq_out_q <= irq_out_d;
            irq_oe_n_q <= ~irq_out_d;
            gap_q <= gap_d;
        end
    end

    // ==========================================================
    // host clock divider
    logic [HALF_W-1:0] clk_cnt_q, clk_cnt_d;
    logic clk_lvl_q, clk_lvl_d, clk_run;

    always_comb begin
        clk_run = state_q == ST_IDLE || state_q == ST_RX ||
                  state_q == ST_TX ||
                  (state_q == ST_DOZE && clksel_q >= DOZE_MAX_SEL);
        clk_cnt_d = clk_cnt_q + HALF_W'(1);
        clk_lvl_d = clk_lvl_q;
        if (clk_cnt_q >= rhc_half(clksel_q) - HALF_W'(1)) begin
            clk_cnt_d = '0;
            clk_lvl_d = ~clk_lvl_q; // see [RULE6]
        end
        if (!clk_run) begin
            clk_cnt_d = '0;
            clk_lvl_d = 1'b0;
        end
    end

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            clk_cnt_q <= '0;
            clk_lvl_q <= 1'b0;
        end else begin
            clk_cnt_q <= clk_cnt_d;
            clk_lvl_q <= clk_lvl_d;
        end
    end

    // ==========================================================
    // status snapshot and pin drivers
    // status only moves outside a frame, so the link sees a still word
    logic [WORD_W-1:0] stat_q, stat_d;
    logic miso_oe_n_q, miso_oe_n_d, irq_lvl_q;

    always_comb begin
        stat_d = stat_q;
        if (cs_n_s) begin
            stat_d = '0;
            stat_d[STAT_IRQ] = irq_out_q;
            stat_d[STAT_TX] = seq_tx_q;
            stat_d[STAT_DRV] = miso_drv_q;
            stat_d[STAT_CLK +: CLKSEL_W] = clksel_q;
            stat_d[STAT_BUSY] = state_q == ST_RX || state_q == ST_TX;
        end
        miso_oe_n_d = ~(~cs_n_s | miso_drv_q); // see [RULE11]
    end

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            stat_q <= '0;
            miso_oe_n_q <= 1'b1;
            irq_lvl_q <= 1'b0;
        end else begin
            stat_q <= stat_d;
            miso_oe_n_q <= miso_oe_n_d;
            irq_lvl_q <= 1'b0;
        end
    end

    assign lnk.status = stat_q;
    assign miso_o = lnk.miso;
    assign miso_oe_n_o = miso_oe_n_q;
    assign irq_n_o = irq_lvl_q;
    assign irq_oe_n_o = irq_oe_n_q; // see [RULE8]
    assign host_clock_out_o = clk_lvl_q;
    assign state_o = state_q;

    // ==========================================================
    // checks
    logic [GAP_W-1:0] since_q;
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            since_q <= '1;
        end else if ($rose(irq_out_q)) begin
            since_q <= '0;
        end else if (since_q != '1) begin
            since_q <= since_q + GAP_W'(1);
        end
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);

    chk_off_reset: assert property ( // see [RULE1]
        !rst_pin_s |=> state_q == ST_OFF && !irq_out_q)
        else $error("reset pin low did not force off");
    chk_idle_default: assert property ( // see [RULE2]
        state_q == ST_OFF && rst_pin_s |=>
        state_q == ST_IDLE && clksel_q == CLKSEL_RST && !miso_drv_q)
        else $error("release did not reach idle with defaults");
    chk_edge_start: assert property ( // see [RULE3]
        state_q == ST_IDLE && trig_rise && rst_pin_s |=>
        state_q == (seq_tx_q ? ST_TX : ST_RX))
        else $error("trigger edge did not start sequence");
    chk_start_level: assert property ( // see [RULE4]
        state_q == ST_IDLE && cmd_v && cmd == CMD_START && !trig_s &&
        rst_pin_s |=> state_q == ST_IDLE)
        else $error("start command ran without trigger high");
    chk_wake_idle: assert property ( // see [RULE5]
        (state_q == ST_HIBERNATE || state_q == ST_DOZE) && !wake_n_s &&
        rst_pin_s |=> state_q == ST_IDLE)
        else $error("wake request ignored");
    chk_irq_spacing: assert property ( // see [RULE8]
        $rose(irq_out_q) |-> since_q >= GAP_W'(IRQ_GAP_CYCLES - 1))
        else $error("interrupts closer than the minimum gap");
    chk_miso_float: assert property ( // see [RULE11]
        cs_n_s && !miso_drv_q ##1 cs_n_s |-> miso_oe_n_q)
        else $error("data out driven while deselected");
    chk_clk_halt: assert property ( // see [RULE6]
        state_q == ST_HIBERNATE [*2] |-> !clk_lvl_q)
        else $error("host clock runs in hibernate");
    chk_seq_len: assert property ( // see [RULE3]
        state_q == ST_IDLE ##1 state_q == ST_RX |->
        state_q == ST_RX [*8])
        else $error("sequence ended too early");
endmodule : rhc_top

// ---- hdl/rhc_pkg.sv ----
// Constants, command codes and state type of the radio host control block.
package rhc_pkg;
    // ==========================================================
    // clocking and timing
    localparam longint CORE_HZ = 100_000_000;
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam longint REF_HZ = 16_000_000;
    localparam int unsigned SEQ_TIME_NS = 144_000;
    localparam int unsigned SEQ_CYCLES = SEQ_TIME_NS / CLK_PERIOD_NS;
    localparam int unsigned IRQ_GAP_NS = 6_000;
    localparam int unsigned IRQ_GAP_CYCLES =
        (IRQ_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned HALF_W = 16;
    localparam int unsigned GAP_W = 10;

    // ==========================================================
    // serial command word: [7:5] command, [4:0] argument
    localparam int unsigned WORD_W = 8;
    localparam int unsigned CMD_LSB = 5;
    localparam int unsigned CMD_W = 3;
    localparam int unsigned ARG_W = 5;
    localparam logic [CMD_W-1:0] CMD_CLKSEL = 3'h1;
    localparam logic [CMD_W-1:0] CMD_SEQSEL = 3'h2;
    localparam logic [CMD_W-1:0] CMD_START = 3'h3;
    localparam logic [CMD_W-1:0] CMD_HIBERNATE = 3'h4;
    localparam logic [CMD_W-1:0] CMD_DOZE = 3'h5;
    localparam logic [CMD_W-1:0] CMD_MISOCFG = 3'h6;
    localparam logic [CMD_W-1:0] CMD_IRQACK = 3'h7;

    // ==========================================================
    // status word shifted back, bit positions
    localparam int unsigned STAT_IRQ = 6;
    localparam int unsigned STAT_TX = 5;
    localparam int unsigned STAT_DRV = 4;
    localparam int unsigned STAT_CLK = 1;
    localparam int unsigned STAT_BUSY = 0;

    // ==========================================================
    // host clock select and resets
    localparam int unsigned CLKSEL_W = 3;
    localparam logic [CLKSEL_W-1:0] CLKSEL_RST = 3'h6;
    localparam logic [CLKSEL_W-1:0] DOZE_MAX_SEL = 3'h4;
    localparam logic SEQ_TX_RST = 1'b0;
    localparam logic MISO_DRV_RST = 1'b0;
    // idle pin levels: reset pin low, trigger low, wake high, select high
    localparam logic [4:0] SYNC_RST = 5'h06;

    typedef enum logic [2:0] {
        ST_OFF, ST_IDLE, ST_HIBERNATE, ST_DOZE, ST_RX, ST_TX
    } rhc_state_e;

    // half period in core cycles for each select code
    function automatic logic [HALF_W-1:0] rhc_half(
        input logic [CLKSEL_W-1:0] sel);
        longint div;
        unique case (sel)
            3'h0: div = 1;
            3'h1: div = 2;
            3'h2: div = 4;
            3'h3: div = 8;
            3'h4: div = 16;
            3'h5: div = 256;
            3'h6: div = 488;
            3'h7: div = 976;
        endcase
        return HALF_W'((CORE_HZ * div + REF_HZ) / (2 * REF_HZ));
    endfunction : rhc_half
endpackage : rhc_pkg

// ---- hdl/rhc_link_if.sv ----
// Carrier between the serial link logic and the core logic.
`timescale 1ns/1ps
interface rhc_link_if;
    import rhc_pkg::*;
    logic [WORD_W-1:0] word;
    logic word_tgl;
    logic [WORD_W-1:0] status;
    logic miso;
    modport link (output word, output word_tgl, output miso, input status);
    modport core (input word, input word_tgl, input miso, output status);
endinterface : rhc_link_if

// ---- hdl/rhc_serial_link.sv ----
// Serial link shifter running on the host's serial clock.
`timescale 1ns/1ps
module rhc_serial_link (
    input wire logic serial_clock_in,
    input wire logic sys_rst_i,
    input wire logic chip_sel_n_i,
    input wire logic mosi_i,
    rhc_link_if.link lnk
);
    import rhc_pkg::*;

    logic [3:0] cnt_q, cnt_d;
    logic [WORD_W-2:0] sh_q, sh_d;
    logic [WORD_W-1:0] word_q, word_d;
    logic tgl_q, tgl_d;
    logic miso_q, miso_d;
    logic frame_rst;

    // ==========================================================
    // frame logic, cleared whenever the host deselects
    assign frame_rst = sys_rst_i | chip_sel_n_i; // see [RULE7]

    always_comb begin
        cnt_d = cnt_q + 4'h1;
        sh_d = {sh_q[WORD_W-3:0], mosi_i}; // see [RULE10]
        word_d = word_q;
        tgl_d = tgl_q;
        if (cnt_q == 4'h7) begin
            word_d = {sh_q, mosi_i};
            tgl_d = ~tgl_q;
        end
        if (cnt_q == 4'h8) begin
            cnt_d = cnt_q; // extra clocks are ignored
        end
        miso_d = 1'b0;
        if (cnt_q != 4'h0 && cnt_q < 4'h8) begin
            miso_d = lnk.status[3'(4'h7 - cnt_q)]; // see [RULE10]
        end
    end

    always_ff @(posedge serial_clock_in or posedge frame_rst) begin
        if (frame_rst) begin
            cnt_q <= 4'h0;
            sh_q <= '0;
        end else begin
            cnt_q <= cnt_d;
            sh_q <= sh_d;
        end
    end

    // word survives deselect so the core can still read it
    always_ff @(posedge serial_clock_in or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            word_q <= '0;
            tgl_q <= 1'b0;
        end else begin
            word_q <= word_d;
            tgl_q <= tgl_d;
        end
    end

    always_ff @(negedge serial_clock_in or posedge frame_rst) begin
        if (frame_rst) begin
            miso_q <= 1'b0;
        end else begin
            miso_q <= miso_d; // see [RULE10]
        end
    end

    assign lnk.word = word_q;
    assign lnk.word_tgl = tgl_q;
    assign lnk.miso = miso_q;

    chk_word_done: assert property ( // see [RULE10]
        @(posedge serial_clock_in) disable iff (frame_rst)
        cnt_q == 4'h7 |=> tgl_q != $past(tgl_q) && word_q[0] == $past(mosi_i))
        else $error("word not captured on eighth leading edge");
endmodule : rhc_serial_link

// ---- verification/rhc_host_model.sv ----
// Host controller model: serial master that owns the link clock.
`timescale 1ns/1ps
module rhc_host_model (
    input wire logic miso_i,
    input wire logic miso_oe_n_i,
    output logic serial_clock_o,
    output logic chip_sel_n_o,
    output logic mosi_o
);
    // ==========================================================
    // frames; the link clock stands still low between them
    initial begin
        serial_clock_o = 1'b0;
        chip_sel_n_o = 1'b1;
        mosi_o = 1'b0;
    end

    task automatic frame(input logic [7:0] word, input int nbits,
                         output logic [7:0] rx);
        realtime t0;
        logic seen;
        t0 = $realtime;
        rx = 8'h00;
        #3 chip_sel_n_o = 1'b0;
        for (int i = 0; i < nbits; i++) begin
            mosi_o = word[7-i];
            #40 serial_clock_o = 1'b1;
            // a floating line is read as the inverse of what it showed
            #40 seen = miso_oe_n_i ? ~miso_i : miso_i;
            rx = {rx[6:0], seen};
            serial_clock_o = 1'b0;
        end
        #40 chip_sel_n_o = 1'b1;
        mosi_o = ~mosi_o;
        while ($realtime - t0 < 3000.0) #10;
    endtask : frame
endmodule : rhc_host_model

// ---- verification/rhc_top_tb_top.sv ----
// Self-checking bench of the radio host control pins.
`timescale 1ns/1ps
module rhc_top_tb_top;
    import rhc_pkg::*;
    localparam int unsigned SEQ_N = 20;
    logic clock_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic reset_n = 1'b0;
    logic trig = 1'b0;
    logic wake_n = 1'b1;
    logic sck, cs_n, mosi, miso, miso_oe_n, irq_n, irq_oe_n, hclk;
    logic irq_line;
    logic [2:0] state;
    logic [7:0] st;
    int fail_count = 0;
    int samples_checked = 0;
    int cyc_n = 0;
    int busy_cyc = 0;
    int h;
    int b;
    int t1;
    int divs[8] = '{1, 2, 4, 8, 16, 256, 488, 976};

    // ==========================================================
    // pins and instances
    assign irq_line = irq_oe_n ? 1'b1 : irq_n;
    always #5 clock_i = ~clock_i;
    always @(posedge clock_i) begin
        cyc_n <= cyc_n + 1;
        if (state === ST_RX || state === ST_TX) begin
            busy_cyc <= busy_cyc + 1;
        end
    end

    rhc_top #(.SEQ_CYC(SEQ_N)) rhc_top_inst (
        .clock_i(clock_i), .sys_rst_i(sys_rst_i), .reset_n_i(reset_n),
        .rx_tx_trigger_i(trig), .wake_request_n_i(wake_n),
        .serial_clock_in(sck), .chip_sel_n_i(cs_n), .mosi_i(mosi),
        .miso_o(miso), .miso_oe_n_o(miso_oe_n), .irq_n_o(irq_n),
        .irq_oe_n_o(irq_oe_n), .host_clock_out_o(hclk), .state_o(state)
    );
    rhc_host_model rhc_host_model_inst (
        .miso_i(miso), .miso_oe_n_i(miso_oe_n), .serial_clock_o(sck),
        .chip_sel_n_o(cs_n), .mosi_o(mosi)
    );

    // ==========================================================
    // shared tasks
    task automatic give_verdict();
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : give_verdict

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: saw %0h expected %0h",
                     $time, seen, exp);
        end
    endtask : check

    task automatic cyc(input int n);
        repeat (n) @(negedge clock_i);
    endtask : cyc

    task automatic wait_state(input logic [2:0] exp, input int lim);
        for (int n = 0; n < lim && state !== exp; n++) @(negedge clock_i);
        if (state !== exp) begin
            check(16'(state), 16'(exp));
            give_verdict();
        end
    endtask : wait_state

    task automatic send(input logic [2:0] c, input logic [4:0] a);
        rhc_host_model_inst.frame({c, a}, 8, st);
        cyc(8);
    endtask : send

    // a select change may cut the running phase short, so count twice
    task automatic measure_half(output int n);
        for (int k = 0; k < 2; k++) begin
            for (int w = 0; w < 8000 && hclk !== 1'b0; w++) cyc(1);
            for (int w = 0; w < 8000 && hclk !== 1'b1; w++) cyc(1);
            for (n = 0; n < 8000 && hclk === 1'b1; n++) cyc(1);
        end
    endtask : measure_half

    function automatic int exp_half(input int s);
        return int'((CORE_HZ * divs[s] + REF_HZ) / (2 * REF_HZ));
    endfunction : exp_half

    // ==========================================================
    // scenarios
    task automatic t_reset();
        cyc(5);
        check(16'(state), 16'(ST_OFF));
        reset_n = 1'b1;
        wait_state(ST_IDLE, 10);
        check(16'(miso_oe_n), 16'h1);
        check(16'(irq_line), 16'h1);
        measure_half(h);
        check(16'(h), 16'(exp_half(6)));
        send(3'h0, 5'h00);
        check(16'(st), {8'h00, 2'b00, SEQ_TX_RST, MISO_DRV_RST,
              CLKSEL_RST, 1'b0});
    endtask : t_reset

    task automatic t_clksel();
        for (int s = 0; s < 8; s++) begin
            send(CMD_CLKSEL, 5'(s));
            measure_half(h);
            check(16'(h), 16'(exp_half(s)));
        end
        send(CMD_CLKSEL, 5'h06);
        check(16'(st[3:1]), 16'h7);
    endtask : t_clksel

    task automatic t_trigger();
        send(CMD_SEQSEL, 5'h01);
        trig = 1'b1;
        cyc(2);
        check(16'(state), 16'(ST_IDLE));
        wait_state(ST_TX, 4);
        trig = 1'b0;
        wait_state(ST_IDLE, SEQ_N + 5);
        for (int n = 0; n < 5 && irq_line !== 1'b0; n++) cyc(1);
        check(16'(irq_line), 16'h0);
        t1 = cyc_n;
        send(CMD_IRQACK, 5'h00);
        check(16'(irq_line), 16'h1);
        trig = 1'b1;
        wait_state(ST_TX, 6);
        trig = 1'b0;
        for (int n = 0; n < 1000 && irq_line !== 1'b0; n++) cyc(1);
        check(16'(irq_line), 16'h0);
        check(16'(cyc_n - t1 >= int'(IRQ_GAP_CYCLES)), 16'h1);
        send(3'h0, 5'h00);
        check(16'(st), {8'h00, 3'b011, MISO_DRV_RST, 3'h6,
              1'b0});
        send(CMD_SEQSEL, 5'h00);
        send(CMD_IRQACK, 5'h00);
        trig = 1'b1;
        wait_state(ST_RX, 6);
        trig = 1'b0;
        wait_state(ST_IDLE, SEQ_N + 5);
    endtask : t_trigger

    task automatic t_start();
        b = busy_cyc;
        send(CMD_START, 5'h00);
        check(16'(busy_cyc - b), 16'h0);
        trig = 1'b1;
        wait_state(ST_RX, 6);
        wait_state(ST_IDLE, SEQ_N + 5);
        b = busy_cyc;
        send(CMD_START, 5'h00);
        h = busy_cyc - b;
        check(16'(h >= SEQ_N && h <= SEQ_N + 1), 16'h1);
        trig = 1'b0;
        send(CMD_IRQACK, 5'h00);
    endtask : t_start

    task automatic t_sleep();
        send(CMD_HIBERNATE, 5'h00);
        wait_state(ST_HIBERNATE, 10);
        cyc(10);
        check(16'(hclk), 16'h0);
        send(CMD_CLKSEL, 5'h00);
        wake_n = 1'b0;
        wait_state(ST_IDLE, 6);
        wake_n = 1'b1;
        send(3'h0, 5'h00);
        check(16'(st[3:1]), 16'h6);
        send(CMD_DOZE, 5'h00);
        wait_state(ST_DOZE, 10);
        wake_n = 1'b0;
        wait_state(ST_IDLE, 6);
        wake_n = 1'b1;
    endtask : t_sleep

    task automatic t_link();
        rhc_host_model_inst.frame({CMD_HIBERNATE, 5'h00}, 4, st);
        cyc(8);
        check(16'(state), 16'(ST_IDLE));
        send(CMD_MISOCFG, 5'h01);
        check(16'(miso_oe_n), 16'h0);
        send(CMD_CLKSEL, 5'h02);
        reset_n = 1'b0;
        wait_state(ST_OFF, 5);
        reset_n = 1'b1;
        wait_state(ST_IDLE, 6);
        check(16'(miso_oe_n), 16'h1);
        send(3'h0, 5'h00);
        check(16'(st), {8'h00, 2'b00, SEQ_TX_RST, MISO_DRV_RST,
              CLKSEL_RST, 1'b0});
    endtask : t_link

    initial begin
        cyc(16);
        sys_rst_i = 1'b0;
        t_reset();
        t_clksel();
        t_trigger();
        t_start();
        t_sleep();
        t_link();
        give_verdict();
    end
endmodule : rhc_top_tb_top
